// ### serial_memory_defines.vh
// constants shared by the serial memory pin interface and its read fifo
// assumes inclusion by bare name from files in the same folder
`ifndef SERIAL_MEMORY_DEFINES_VH
`define SERIAL_MEMORY_DEFINES_VH

// ************************************************************
// array shape
// ************************************************************
`define MEM_ADDR_W        17
`define MEM_DEPTH         131072
`define MEM_DATA_W        8

// ************************************************************
// command codes
// ************************************************************
`define CMD_WREN          8'h06
`define CMD_WRDI          8'h04
`define CMD_RDSR          8'h05
`define CMD_WRSR          8'h01
`define CMD_READ          8'h03
`define CMD_WRITE         8'h02
`define CMD_SLEEP         8'hB9
`define CMD_WAKE          8'hAB
`define CMD_NONE          8'h00

// ************************************************************
// status register fields and reset value
// ************************************************************
`define SR_WD_BIT         7
`define SR_BP1_BIT        3
`define SR_BP0_BIT        2
`define SR_WEL_BIT        1
`define SR_RESET          8'h00
`define SR_WRITE_MASK     8'hFD

// ************************************************************
// frame byte positions and timing
// ************************************************************
`define BYTE_CMD          3'h0
`define BYTE_DATA         3'h4
`define SCK_MAX_MHZ       40
`define REF_CLK_MHZ       100
`define SCK_MIN_HALF_CYC  ((`REF_CLK_MHZ) / (2 * `SCK_MAX_MHZ))
`define READ_FIFO_DEPTH   8
`define READ_FIFO_AW      3

`endif

// ### byte_fifo.v
// small synchronous fifo with valid/ready on both sides and a flush
// assumes one clock domain and a synchronous active low reset
`timescale 1ns/1ns

module byte_fifo #(
   parameter WIDTH = 8,
   parameter DEPTH = 8,
   parameter AW    = 3
) (
   input  wire             clk,        // system clock
   input  wire             rstn,       // synchronous reset, active low
   input  wire             flush,      // drop all contents
   input  wire [WIDTH-1:0] in_data,    // write data
   input  wire             in_valid,   // write request
   output wire             in_ready,   // room available
   output wire [WIDTH-1:0] out_data,   // head word
   output wire             out_valid,  // head word present
   input  wire             out_ready   // consumer takes head
);

   reg [WIDTH-1:0] store_reg [0:DEPTH-1];
   reg [AW-1:0]    wr_ptr_reg;
   reg [AW-1:0]    rd_ptr_reg;
   reg [AW:0]      count_reg;
   wire            push;
   wire            pop;

   assign in_ready  = (count_reg != DEPTH[AW:0]);
   assign out_valid = (count_reg != {(AW+1){1'b0}});
   assign out_data  = store_reg[rd_ptr_reg];
   assign push      = in_valid & in_ready & ~flush;
   assign pop       = out_ready & out_valid & ~flush;

   always @(posedge clk) begin
      if (push) begin
         store_reg[wr_ptr_reg] <= in_data;
      end
   end

   always @(posedge clk) begin
      if (!rstn || flush) begin
         wr_ptr_reg <= {AW{1'b0}};
         rd_ptr_reg <= {AW{1'b0}};
         count_reg  <= {(AW+1){1'b0}};
      end else begin
         if (push) begin
            wr_ptr_reg <= (wr_ptr_reg == DEPTH[AW-1:0] - 1'b1) ? {AW{1'b0}} : wr_ptr_reg + 1'b1;
         end
         if (pop) begin
            rd_ptr_reg <= (rd_ptr_reg == DEPTH[AW-1:0] - 1'b1) ? {AW{1'b0}} : rd_ptr_reg + 1'b1;
         end
         if (push && !pop) begin
            count_reg <= count_reg + 1'b1;
         end else if (pop && !push) begin
            count_reg <= count_reg - 1'b1;
         end
      end
   end

endmodule // byte_fifo

// ### serial_memory_spi.v
// pin-level serial interface and byte array of a serial nonvolatile memory
// assumes all pins are asynchronous to ref_clk and the link clock is slow
// enough to be oversampled after a two-stage synchroniser
//
// Operation
// - chip select high: ignore inputs, standby
// - drive output only returning read data
// - suspend low forces output off
// - output changes on serial clock fall
// - input sampled on serial clock rise
// - serial clock up to 40 MHz
// - modes 0 and 3, capture on rise
// - static logic, clock may stop anywhere
// - suspend low pauses current access
// - write protect low blocks status writes
// - array of 131072 bytes
// - random access, no write busy time
// - mode taken from clock at select fall
// - one command per select period
`timescale 1ns/1ns
`include "serial_memory_defines.vh"

module serial_memory_spi #(
   parameter ADDR_W    = `MEM_ADDR_W,
   parameter DEPTH     = `MEM_DEPTH,
   parameter FIFO_D    = `READ_FIFO_DEPTH,
   parameter FIFO_AW   = `READ_FIFO_AW
) (
   input  wire ref_clk,    // system clock, 100 MHz
   input  wire rstn,       // synchronous reset, active low
   input  wire cs_n,       // chip select pin, active low
   input  wire sck,        // serial clock pin
   input  wire si,         // serial data in pin
   input  wire hold_n,     // suspend pin, active low
   input  wire wp_n,       // write protect pin, active low
   output wire so,         // serial data out
   output wire so_oe,      // serial out drive enable, high drives
   output wire standby,    // low power standby indication
   output wire spi_mode    // link mode of frame, 0 or 3 as 0/1
);

   // ************************************************************
   // pin synchronisers
   // ************************************************************
   reg  [4:0] sync1_reg;
   reg  [4:0] sync2_reg;
   wire       cs_s;
   wire       sck_s;
   wire       si_s;
   wire       hold_s;
   wire       wp_s;

   always @(posedge ref_clk) begin
      if (!rstn) begin
         sync1_reg <= 5'h13;
         sync2_reg <= 5'h13;
      end else begin
         sync1_reg <= {cs_n, sck, si, hold_n, wp_n};
         sync2_reg <= sync1_reg;
      end
   end

   assign cs_s   = sync2_reg[4];
   assign sck_s  = sync2_reg[3];
   assign si_s   = sync2_reg[2];
   assign hold_s = sync2_reg[1];
   assign wp_s   = sync2_reg[0];

   // ************************************************************
   // edge detection, gated by suspend
   // ************************************************************
   reg  sck_prev_reg;
   reg  sel_reg;
   wire run;
   wire rise;
   wire fall;
   wire sel_start;
   wire sel_end;

   always @(posedge ref_clk) begin
      if (!rstn) begin
         sck_prev_reg <= 1'b0;
      end else begin
         sck_prev_reg <= sck_s;
      end
   end

   assign run       = hold_s;
   assign rise      = run & sel_reg & sck_s & ~sck_prev_reg;
   assign fall      = run & sel_reg & ~sck_s & sck_prev_reg;
   assign sel_start = run & ~cs_s & ~sel_reg;
   assign sel_end   = run & cs_s & sel_reg;

   // ************************************************************
   // functions
   // ************************************************************
   function blk_prot;
      input [1:0]        bp;
      input [ADDR_W-1:0] a;
      begin
         case (bp)
            2'h0:    blk_prot = 1'b0;
            2'h1:    blk_prot = (a[ADDR_W-1:ADDR_W-2] == 2'h3);
            2'h2:    blk_prot = a[ADDR_W-1];
            default: blk_prot = 1'b1;
         endcase
      end
   endfunction

   function [ADDR_W-1:0] addr_inc;
      input [ADDR_W-1:0] a;
      begin
         addr_inc = (a == DEPTH[ADDR_W-1:0] - 1'b1) ? {ADDR_W{1'b0}} : a + 1'b1;
      end
   endfunction

   // ************************************************************
   // frame state
   // ************************************************************
   reg  [7:0]        mem_reg [0:DEPTH-1];
   reg  [7:0]        status_reg;
   reg               sleep_reg;
   reg               mode_reg;
   reg  [7:0]        cmd_reg;
   reg  [2:0]        bit_cnt_reg;
   reg  [2:0]        byte_cnt_reg;
   reg  [6:0]        in_shift_reg;
   reg  [ADDR_W-1:0] addr_reg;
   reg  [ADDR_W-1:0] rd_addr_reg;
   reg               fill_en_reg;
   reg  [2:0]        out_cnt_reg;
   reg  [6:0]        out_shift_reg;
   reg               so_reg;
   reg               out_act_reg;
   wire [7:0]        in_byte;
   wire              byte_done;
   wire              out_phase;
   wire              load;
   wire [7:0]        fifo_data;
   wire              fifo_valid;
   wire              fifo_in_ready;
   wire              fifo_pop;
   wire              fifo_flush;
   wire              sr_ok;
   wire              wr_ok;

   assign in_byte    = {in_shift_reg, si_s};
   assign byte_done  = rise & (bit_cnt_reg == 3'h7);
   assign out_phase  = ((cmd_reg == `CMD_READ) && (byte_cnt_reg == `BYTE_DATA)) ||
                       ((cmd_reg == `CMD_RDSR) && (byte_cnt_reg != `BYTE_CMD));
   assign load       = fall & out_phase & (out_cnt_reg == 3'h0);
   assign fifo_pop   = load & (cmd_reg == `CMD_READ);
   assign fifo_flush = sel_start | sel_end;
   assign sr_ok      = status_reg[`SR_WEL_BIT] & wp_s;
   assign wr_ok      = status_reg[`SR_WEL_BIT] &
                       ~blk_prot(status_reg[`SR_BP1_BIT:`SR_BP0_BIT], addr_reg);

   // ************************************************************
   // select framing, input shifting, command decode
   // ************************************************************
   always @(posedge ref_clk) begin
      if (!rstn) begin
         sel_reg      <= 1'b0;
         mode_reg     <= 1'b0;
         cmd_reg      <= `CMD_NONE;
         bit_cnt_reg  <= 3'h0;
         byte_cnt_reg <= `BYTE_CMD;
         in_shift_reg <= 7'h00;
         addr_reg     <= {ADDR_W{1'b0}};
         status_reg   <= `SR_RESET;
         sleep_reg    <= 1'b0;
      end else if (sel_start) begin
         sel_reg      <= 1'b1;
         mode_reg     <= sck_s;
         cmd_reg      <= `CMD_NONE;
         bit_cnt_reg  <= 3'h0;
         byte_cnt_reg <= `BYTE_CMD;
      end else if (sel_end) begin
         sel_reg      <= 1'b0;
         cmd_reg      <= `CMD_NONE;
         bit_cnt_reg  <= 3'h0;
         byte_cnt_reg <= `BYTE_CMD;
      end else if (rise) begin
         // counters only move on edges, so a stopped clock keeps position
         bit_cnt_reg  <= bit_cnt_reg + 1'b1;
         in_shift_reg <= in_byte[6:0];
         if (byte_done) begin
            if (byte_cnt_reg != `BYTE_DATA) begin
               byte_cnt_reg <= byte_cnt_reg + 1'b1;
            end
            if (byte_cnt_reg == `BYTE_CMD) begin
               if (sleep_reg && in_byte != `CMD_WAKE) begin
                  cmd_reg <= `CMD_NONE;
               end else begin
                  cmd_reg <= in_byte;
               end
               if (!sleep_reg || in_byte == `CMD_WAKE) begin
                  case (in_byte)
                     `CMD_WREN:  status_reg[`SR_WEL_BIT] <= 1'b1;
                     `CMD_WRDI:  status_reg[`SR_WEL_BIT] <= 1'b0;
                     `CMD_SLEEP: sleep_reg <= 1'b1;
                     `CMD_WAKE:  sleep_reg <= 1'b0;
                     default:    sleep_reg <= sleep_reg;
                  endcase
               end
            end else if (cmd_reg == `CMD_WRSR) begin
               if (byte_cnt_reg == 3'h1 && sr_ok) begin
                  status_reg <= (in_byte & `SR_WRITE_MASK) |
                                (status_reg & ~`SR_WRITE_MASK);
               end
            end else if (cmd_reg == `CMD_READ || cmd_reg == `CMD_WRITE) begin
               if (byte_cnt_reg != `BYTE_DATA) begin
                  addr_reg <= {addr_reg[ADDR_W-9:0], in_byte};
               end else begin
                  addr_reg <= addr_inc(addr_reg);
               end
            end
         end
      end
   end

   // ************************************************************
   // array write, committed at byte end with no busy time
   // ************************************************************
   always @(posedge ref_clk) begin
      if (byte_done && cmd_reg == `CMD_WRITE && byte_cnt_reg == `BYTE_DATA && wr_ok) begin
         mem_reg[addr_reg] <= in_byte;
      end
   end

   // ************************************************************
   // read prefetch into fifo
   // ************************************************************
   always @(posedge ref_clk) begin
      if (!rstn || fifo_flush) begin
         fill_en_reg <= 1'b0;
         rd_addr_reg <= {ADDR_W{1'b0}};
      end else if (byte_done && cmd_reg == `CMD_READ && byte_cnt_reg == 3'h3) begin
         fill_en_reg <= 1'b1;
         rd_addr_reg <= {addr_reg[ADDR_W-9:0], in_byte};
      end else if (fill_en_reg && fifo_in_ready) begin
         rd_addr_reg <= addr_inc(rd_addr_reg);
      end
   end

   byte_fifo #(
      .WIDTH     (8),
      .DEPTH     (FIFO_D),
      .AW        (FIFO_AW)
   ) u_read_fifo (
      .clk       (ref_clk),
      .rstn      (rstn),
      .flush     (fifo_flush),
      .in_data   (mem_reg[rd_addr_reg]),
      .in_valid  (fill_en_reg),
      .in_ready  (fifo_in_ready),
      .out_data  (fifo_data),
      .out_valid (fifo_valid),
      .out_ready (fifo_pop)
   );

   // ************************************************************
   // output serialiser, moves on falling edges only
   // ************************************************************
   always @(posedge ref_clk) begin
      if (!rstn || fifo_flush) begin
         out_cnt_reg   <= 3'h0;
         out_shift_reg <= 7'h00;
         so_reg        <= 1'b0;
         out_act_reg   <= 1'b0;
      end else if (load) begin
         out_act_reg <= 1'b1;
         out_cnt_reg <= 3'h1;
         if (cmd_reg == `CMD_READ) begin
            so_reg        <= fifo_valid ? fifo_data[7] : 1'b0;
            out_shift_reg <= fifo_valid ? fifo_data[6:0] : 7'h00;
         end else begin
            so_reg        <= status_reg[7];
            out_shift_reg <= status_reg[6:0];
         end
      end else if (fall && out_cnt_reg != 3'h0) begin
         so_reg        <= out_shift_reg[6];
         out_shift_reg <= {out_shift_reg[5:0], 1'b0};
         out_cnt_reg   <= out_cnt_reg + 1'b1;
      end
   end

   // ************************************************************
   // pin outputs
   // ************************************************************
   assign so       = so_reg;
   assign so_oe    = out_act_reg & sel_reg & out_phase & hold_s;
   assign standby  = ~sel_reg;
   assign spi_mode = mode_reg;

endmodule // serial_memory_spi

// ### serial_memory_spi_chk.sv
// port assertions for the serial memory pin interface
// assumes pins change just after ref_clk edges and each sck phase lasts 6 ref_clk or more
`timescale 1ns/1ns
module serial_memory_spi_chk (
   input wire ref_clk,   // system clock
   input wire rstn,      // sync reset, active low
   input wire cs_n,      // chip select pin
   input wire sck,       // serial clock pin
   input wire si,        // serial data in pin
   input wire hold_n,    // suspend pin
   input wire wp_n,      // write protect pin
   input wire so,        // serial data out
   input wire so_oe,     // drive enable
   input wire standby,   // standby flag
   input wire spi_mode   // mode of frame
);
   // ************************************************************
   // helper counters and sequences
   // ************************************************************
   logic [3:0] fall_age;   // cycles since sck fell
   logic [3:0] hold_age;   // cycles since hold_n was low
   always @(posedge ref_clk) begin
      if (!rstn || $fell(sck))
         fall_age <= 4'h0;
      else if (fall_age != 4'hF)
         fall_age <= fall_age + 4'h1;
   end
   always @(posedge ref_clk) begin
      if (!rstn || !hold_n)
         hold_age <= 4'h0;
      else if (hold_age != 4'hF)
         hold_age <= hold_age + 4'h1;
   end
   default clocking @(posedge ref_clk); endclocking
   default disable iff (!rstn);
   sequence idle_run; (cs_n && hold_n) [*6]; endsequence
   sequence frame_start; $fell(cs_n) && hold_n && hold_age > 4'h8; endsequence
   sequence hold_run; (!hold_n) [*4]; endsequence
   sequence deselect; $rose(cs_n) && hold_n; endsequence
   standby_idle_a: assert property (idle_run |-> standby && !so_oe)
      else $error("drive or activity while deselected");
   deselect_drop_a: assert property (deselect |-> ##[1:5] !so_oe)
      else $error("output still driven after deselect");
   hold_quiet_a: assert property (hold_run |-> !so_oe)
      else $error("output driven while suspended");
   hold_freeze_a: assert property (hold_run |=> $stable(so))
      else $error("output moved while suspended");
   hold_ignore_a: assert property (hold_run |=> $stable(standby) && $stable(spi_mode))
      else $error("select or clock acted while suspended");
   fall_only_a: assert property (so_oe && $past(so_oe) && $changed(so) |-> fall_age inside {[4'h1:4'h6]})
      else $error("output changed away from a clock fall");
   drive_cause_a: assert property ($rose(so_oe) && hold_age > 4'h8 |-> fall_age inside {[4'h1:4'h6]} && $past(!cs_n, 3))
      else $error("drive started outside read data");
   mode_pick_a: assert property (frame_start |-> ##5 (!standby && spi_mode == $past(sck, 5)))
      else $error("mode not taken from clock at select");
endmodule // serial_memory_spi_chk

bind serial_memory_spi serial_memory_spi_chk chk (.ref_clk(ref_clk), .rstn(rstn), .cs_n(cs_n), .sck(sck), .si(si),
   .hold_n(hold_n), .wp_n(wp_n), .so(so), .so_oe(so_oe), .standby(standby), .spi_mode(spi_mode));

// ### spi_host_model.sv
// host side of the serial link: frames, bytes, suspend pauses
// assumes ref_clk 100 MHz; sck low 7 and high 6 ref_clk, a 130 ns period
`timescale 1ns/1ns
module spi_host_model (
   input  wire logic       ref_clk,   // system clock
   input  wire logic       so,        // device serial out
   input  wire logic       so_oe,     // device drive enable
   output logic            cs_n,      // chip select, one per device
   output logic            sck,       // serial clock
   output logic            si,        // data to device
   output logic            hold_n,    // suspend line, one per device
   output logic            rx_valid,  // byte received pulse
   output logic [7:0]      rx_byte    // byte received
);
   // ************************************************************
   // line model and transfer tasks
   // ************************************************************
   logic last_so;   // released line shows inverse of last bit
   wire  so_line = so_oe ? so : ~last_so;   // shared data line only read while driven
   initial begin
      cs_n = 1'b1;
      sck = 1'b0;
      si = 1'b0;
      hold_n = 1'b1;
      rx_valid = 1'b0;
      rx_byte = 8'h00;
      last_so = 1'b0;
   end
   always @(posedge ref_clk) begin
      if (so_oe)
         last_so <= so;
   end
   task automatic wait_clk(input int n);
      repeat (n) @(posedge ref_clk);
   endtask
   task automatic frame_open(input logic mode);
      sck <= mode;   // idle level picks the mode
      wait_clk(4);
      cs_n <= 1'b0;
      wait_clk(7);
   endtask
   task automatic frame_close(input logic mode);
      sck <= mode;
      wait_clk(7);
      cs_n <= 1'b1;   // one command per frame, whole bytes
      wait_clk(10);
   endtask
   task automatic byte_io(input logic [7:0] tx, input logic chk, input int hold_at);
      logic [7:0] rx;
      for (int i = 7; i >= 0; i--) begin
         if (i == hold_at) begin
            hold_n <= 1'b0;   // suspend moves only while selected
            wait_clk(5);
            sck <= 1'b0;
            cs_n <= 1'b1;
            wait_clk(4);
            sck <= 1'b1;
            cs_n <= 1'b0;
            wait_clk(5);
            hold_n <= 1'b1;
            wait_clk(5);
         end
         sck <= 1'b0;
         si <= tx[i];
         wait_clk(7);
         rx[i] = so_line;
         sck <= 1'b1;   // 130 ns period, under the rate ceiling
         wait_clk(6);
      end
      if (chk) begin
         rx_byte <= rx;
         rx_valid <= 1'b1;
         wait_clk(1);
         rx_valid <= 1'b0;
      end
   endtask
endmodule // spi_host_model

// ### serial_memory_spi_bench.sv
// self-checking bench for the serial memory pin interface
// assumes the host model and checker are compiled before this file
`timescale 1ns/1ns
`include "serial_memory_defines.vh"
module serial_memory_spi_bench;
   localparam int          DEPTH = 1024;
   localparam logic [23:0] TOP4  = 24'(DEPTH - 4);
   logic       ref_clk;
   logic       rstn;
   logic       wp_n;
   wire        cs_n, sck, si, hold_n, so, so_oe, standby, spi_mode, rx_valid;
   wire  [7:0] rx_byte;
   int         fails;
   int         checks_done;
   logic [7:0] exp_q[$];
   logic [7:0] data[10];
   serial_memory_spi #(.ADDR_W(10), .DEPTH(DEPTH)) uut (.ref_clk(ref_clk), .rstn(rstn), .cs_n(cs_n), .sck(sck),
      .si(si), .hold_n(hold_n), .wp_n(wp_n), .so(so), .so_oe(so_oe), .standby(standby), .spi_mode(spi_mode));
   spi_host_model host (.ref_clk(ref_clk), .so(so), .so_oe(so_oe), .cs_n(cs_n), .sck(sck), .si(si),
      .hold_n(hold_n), .rx_valid(rx_valid), .rx_byte(rx_byte));
   // ************************************************************
   // clock, checking and closing
   // ************************************************************
   initial begin
      ref_clk = 1'b0;
      forever #5 ref_clk = ~ref_clk;
   end
   task automatic check(input logic [7:0] seen, input logic [7:0] want);
      checks_done++;
      if (seen !== want) begin
         fails++;
         $display("BAD t=%0t seen=%h want=%h", $time, seen, want);
      end
   endtask
   task automatic report_and_stop;
      $display("checks %0d mismatches %0d", checks_done, fails);
      if (fails == 0 && checks_done > 0)
         $display("Finished cleanly");
      else
         $display("Finished with errors");
      $finish;
   endtask
   always @(posedge ref_clk) begin
      if (rx_valid && exp_q.size() == 0)
         check(rx_byte, ~rx_byte);
      else if (rx_valid)
         check(rx_byte, exp_q.pop_front());
   end
   // ************************************************************
   // transfers and scenarios
   // ************************************************************
   task automatic cmd(input logic [7:0] op);
      host.frame_open(1'b0);
      host.byte_io(op, 1'b0, 8);
      host.frame_close(1'b0);
   endtask
   task automatic status_io(input logic [7:0] op, input logic [7:0] val);
      host.frame_open(1'b0);
      host.byte_io(op, 1'b0, 8);
      if (op == `CMD_RDSR)
         exp_q.push_back(val);
      host.byte_io(val, op == `CMD_RDSR, 8);
      host.frame_close(1'b0);
   endtask
   task automatic mem_access(input logic [7:0] op, input logic mode, input logic [23:0] addr, input int n,
                             input int hold_at);
      host.frame_open(mode);
      check({7'h00, spi_mode}, {7'h00, mode});
      check({7'h00, standby}, 8'h00);
      host.byte_io(op, 1'b0, 8);
      for (int k = 2; k >= 0; k--)
         host.byte_io(addr[k*8 +: 8], 1'b0, 8);
      for (int k = 0; k < n; k++) begin
         if (op == `CMD_READ)
            exp_q.push_back(data[k]);
         host.byte_io(data[k], op == `CMD_READ, k == 1 ? hold_at : 8);
      end
      host.frame_close(mode);
      check({7'h00, standby}, 8'h01);
      check({7'h00, so_oe}, 8'h00);
   endtask
   initial begin
      rstn = 1'b0;
      wp_n = 1'b1;
      fails = 0;
      checks_done = 0;
      void'($urandom(96755));
      repeat (6) @(posedge ref_clk);
      rstn <= 1'b1;
      repeat (3) @(posedge ref_clk);
      foreach (data[k])
         data[k] = 8'($urandom);
      cmd(`CMD_WREN);
      mem_access(`CMD_WRITE, 1'b0, TOP4, 10, 8);   // wraps past the top, no busy gap
      mem_access(`CMD_READ, 1'b0, TOP4, 10, 8);    // ten bytes pass the read fifo
      $display("test wrap_write_read done");
      mem_access(`CMD_READ, 1'b1, TOP4, 3, 8);     // idle-high clock
      $display("test mode3_read done");
      mem_access(`CMD_READ, 1'b0, TOP4, 3, 3);     // suspend mid-byte, resume same bit
      $display("test suspend_read done");
      wp_n <= 1'b0;
      status_io(`CMD_WRSR, 8'h8C);
      status_io(`CMD_RDSR, 8'h02);                  // refused while protected
      wp_n <= 1'b1;
      status_io(`CMD_WRSR, 8'h70);
      status_io(`CMD_RDSR, 8'h72);                  // accepted once released
      $display("test write_protect done");
      cmd(`CMD_WRDI);
      status_io(`CMD_WRSR, 8'h00);
      status_io(`CMD_RDSR, 8'h70);                  // latch cleared, write refused
      cmd(`CMD_SLEEP);
      cmd(`CMD_WREN);
      cmd(`CMD_WAKE);
      status_io(`CMD_RDSR, 8'h70);                  // enable ignored while asleep
      cmd(`CMD_WREN);
      status_io(`CMD_WRSR, 8'h7C);
      status_io(`CMD_RDSR, 8'h7E);                  // all blocks protected
      foreach (data[k])
         data[k] = ~data[k];
      mem_access(`CMD_WRITE, 1'b0, TOP4, 3, 8);
      foreach (data[k])
         data[k] = ~data[k];
      mem_access(`CMD_READ, 1'b0, TOP4, 3, 8);     // protected bytes unchanged
      $display("test protect_sleep done");
      check(8'(exp_q.size()), 8'h00);
      report_and_stop();
   end
   initial begin
      repeat (100000) @(posedge ref_clk);
      fails++;
      report_and_stop();
   end
endmodule // serial_memory_spi_bench
